//--- hcbp_bus_if.sv
// pin bundle joining the host end and the device end of the port
// assumes the testbench instantiates it; undriven lines read as pulled high
`timescale 1ns/1ns
interface hcbp_bus_if;
  import hcbp_pkg::*;

  // host driven pins
  logic bus_mode_select_n;
  logic [ADDR_W-1:0] host_reg_index;
  logic chip_select_n;
  logic write_strobe_n;
  logic read_strobe_n;
  logic hw_reset_n;
  logic speed_o;
  logic speed_oe_n;
  logic [DATA_W-1:0] host_data_o;
  logic host_data_oe_n;

  // device driven pins
  logic [DATA_W-1:0] dev_data_o;
  logic dev_data_oe_n;
  logic irq_out_n;

  // resolved wires, pull-ups where nobody drives
  logic [DATA_W-1:0] data_bus;
  logic access_speed_select;

  assign data_bus = !dev_data_oe_n ? dev_data_o : (!host_data_oe_n ? host_data_o : BUS_PULLED);
  assign access_speed_select = !speed_oe_n ? speed_o : 1'b1;

  modport dev (
    input bus_mode_select_n, host_reg_index, chip_select_n, write_strobe_n,
    input read_strobe_n, hw_reset_n, access_speed_select, data_bus,
    output dev_data_o, dev_data_oe_n, irq_out_n
  );

  modport host (
    output bus_mode_select_n, host_reg_index, chip_select_n, write_strobe_n,
    output read_strobe_n, hw_reset_n, speed_o, speed_oe_n, host_data_o, host_data_oe_n,
    input data_bus, irq_out_n
  );
endinterface

//--- hcbp_dev_end.sv
// device end of the host cpu bus port: decodes host strobes into register accesses
// assumes the register file lives in user logic on the same clock
// Functional notes
// [R1] direct mode: three index inputs, bit 0 lowest
// [R2] muxed mode: select low, middle open, ALE; the host end drives the middle index pin high
// [R3] muxed mode latches low address from data
// [R4] upper five data lines carry data only
// [R5] 80xx style: write strobe active low
// [R6] 80xx style: read strobe low drives data
// [R7] 68xx style: direction low write, high read
// [R8] 68xx style: data strobe active low qualifies
// [R9] hardware reset low holds reset state
// [R10] pending interrupt drives interrupt output low
// [R11] strobes honoured only with chip select low
// [R12] fast timing low, only in direct mode
// [R13] high or open selects normal timing
// [R14] index picks one of eight registers
`timescale 1ns/1ns
module hcbp_dev_end
  import hcbp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  hcbp_bus_if.dev bus,
  // strap of the cpu strobe style
  input wire hcbp_pkg::hcbp_cpu_e cpu_style,
  // register file access
  output logic [hcbp_pkg::ADDR_W-1:0] reg_addr_q,
  output logic reg_wr_pulse_q,
  output logic [hcbp_pkg::DATA_W-1:0] reg_wr_data_q,
  output logic reg_rd_pulse_q,
  input wire logic [hcbp_pkg::DATA_W-1:0] reg_rd_data,
  // interrupt request from the core, a level
  input wire logic irq_req,
  // status toward the core
  output logic device_reset_q,
  output logic fast_timing_q,
  output logic timing_conflict_q
);
  import hcbp_pkg::*;

  logic [DEV_PIN_W-1:0] pins_raw;
  logic [DEV_PIN_W-1:0] pins_s;
  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  logic mux_n_s;
  logic speed_s;
  logic hw_rst_n_s;
  logic [ADDR_W-1:0] idx_s;
  logic [DATA_W-1:0] data_s;
  logic in_reset;
  logic mux_mode;
  logic ale;
  logic selected;
  logic data_strobe_n;
  logic wr_act;
  logic rd_act;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] addr_lat_q;
  logic [ADDR_W-1:0] addr_hold_q;
  logic [DATA_W-1:0] data_hold_q;
  logic wr_act_q;
  logic rd_act_q;
  logic [DATA_W-1:0] dev_data_q;
  logic dev_data_oe_n_q;
  logic irq_out_n_q;

  // every host pin passes two flip-flops before use
  assign pins_raw = {bus.chip_select_n, bus.write_strobe_n, bus.read_strobe_n,
                     bus.bus_mode_select_n, bus.access_speed_select, bus.hw_reset_n,
                     bus.host_reg_index, bus.data_bus};

  hcbp_sync #(
    .W(DEV_PIN_W),
    .RST_VAL(DEV_PIN_RST)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {cs_n_s, wr_n_s, rd_n_s, mux_n_s, speed_s, hw_rst_n_s, idx_s, data_s} = pins_s;

  // mode decode
  assign in_reset = !hw_rst_n_s; // see [R9]
  assign mux_mode = !mux_n_s; // see [R2]
  assign ale = mux_mode && idx_s[ALE_BIT]; // see [R2]
  assign selected = !cs_n_s && !ale; // see [R11]
  assign data_strobe_n = rd_n_s;
  assign cur_addr = mux_mode ? addr_lat_q : idx_s; // see [R1]

  // strobe decode per cpu style
  always_comb begin
    wr_act = 1'b0;
    rd_act = 1'b0;
    case (cpu_style)
      HCBP_CPU_80XX: begin
        wr_act = selected && !wr_n_s; // see [R5]
        rd_act = selected && !rd_n_s && wr_n_s; // see [R6]
      end
      HCBP_CPU_68XX: begin
        wr_act = selected && !data_strobe_n && !wr_n_s; // see [R7] [R8]
        rd_act = selected && !data_strobe_n && wr_n_s; // see [R7] [R8]
      end
      default: begin
        wr_act = 1'b0;
        rd_act = 1'b0;
      end
    endcase
    if (in_reset) begin
      wr_act = 1'b0;
      rd_act = 1'b0;
    end
  end

  // address latch: low lines carry the index while ALE is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_lat_q <= '0;
    end else if (in_reset) begin
      addr_lat_q <= '0;
    end else if (ale) begin
      addr_lat_q <= data_s[LOW_W-1:0]; // see [R3]
    end
  end

  // strobe history for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end

  // capture address and write data while a strobe is active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_hold_q <= '0;
      data_hold_q <= '0;
    end else begin
      if (wr_act || rd_act) begin
        addr_hold_q <= cur_addr; // see [R14]
      end
      if (wr_act) begin
        data_hold_q <= data_s; // see [R4]
      end
    end
  end

  // register access toward the core; a write commits at strobe release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr_q <= '0;
      reg_wr_pulse_q <= 1'b0;
      reg_wr_data_q <= '0;
      reg_rd_pulse_q <= 1'b0;
    end else begin
      reg_wr_pulse_q <= wr_act_q && !wr_act && !in_reset; // see [R14]
      reg_rd_pulse_q <= rd_act && !rd_act_q; // see [R14]
      if (wr_act || rd_act) begin
        reg_addr_q <= cur_addr;
      end else if (wr_act_q) begin
        reg_addr_q <= addr_hold_q;
      end
      if (wr_act_q && !wr_act) begin
        reg_wr_data_q <= data_hold_q;
      end
    end
  end

  // read data drive; fast timing opens the bus one cycle sooner
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_data_q <= '0;
      dev_data_oe_n_q <= 1'b1;
    end else begin
      dev_data_q <= reg_rd_data;
      if (fast_timing_q) begin
        dev_data_oe_n_q <= !rd_act; // see [R6] [R12]
      end else begin
        dev_data_oe_n_q <= !(rd_act && rd_act_q); // see [R6] [R13]
      end
    end
  end

  // timing mode: a low select counts only in direct mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_timing_q <= 1'b0;
      timing_conflict_q <= 1'b0;
    end else begin
      fast_timing_q <= !speed_s && !mux_mode; // see [R12] [R13]
      timing_conflict_q <= !speed_s && mux_mode; // see [R12]
    end
  end

  // interrupt pin and reset status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out_n_q <= 1'b1;
      device_reset_q <= 1'b1;
    end else begin
      irq_out_n_q <= !(irq_req && !in_reset); // see [R10]
      device_reset_q <= in_reset; // see [R9]
    end
  end

  assign bus.dev_data_o = dev_data_q;
  assign bus.dev_data_oe_n = dev_data_oe_n_q;
  assign bus.irq_out_n = irq_out_n_q;

endmodule

//--- hcbp_host_end.sv
// host end of the host cpu bus port: runs one register access per command
// assumes the device end samples pins through two flip-flops
`timescale 1ns/1ns
module hcbp_host_end
  import hcbp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  hcbp_bus_if.host bus,
  // configuration levels
  input wire logic cfg_mux,
  input wire hcbp_pkg::hcbp_cpu_e cfg_cpu,
  input wire logic cfg_fast,
  input wire logic reset_req,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [hcbp_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [hcbp_pkg::DATA_W-1:0] cmd_wdata,
  output logic cmd_ready_q,
  // answer
  output logic rsp_valid_q,
  output logic [hcbp_pkg::DATA_W-1:0] rsp_rdata_q,
  output logic irq_pending_q
);
  import hcbp_pkg::*;

  hcbp_hstate_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic write_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [HOST_PIN_W-1:0] in_s;
  logic fast_ok;
  logic [CNT_W-1:0] strobe_len;
  logic [ADDR_W-1:0] idx_q;
  logic mux_n_q;
  logic cs_n_q;
  logic wr_n_q;
  logic rd_n_q;
  logic rst_pin_n_q;
  logic speed_oe_n_q;
  logic [DATA_W-1:0] hdata_q;
  logic hdata_oe_n_q;

  // fast timing only allowed on the direct bus
  assign fast_ok = cfg_fast && !cfg_mux; // see [R12]
  assign strobe_len = fast_ok ? STROBE_FAST_CYC : STROBE_CYC;

  // device pins in through two flip-flops
  hcbp_sync #(
    .W(HOST_PIN_W),
    .RST_VAL(HOST_PIN_RST)
  ) u_in_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({bus.irq_out_n, bus.data_bus}),
    .q(in_s)
  );

  // access sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HCBP_IDLE;
      cnt_q <= '0;
      write_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      case (state_q)
        HCBP_IDLE: begin
          if (cmd_valid && !reset_req) begin
            write_q <= cmd_write;
            addr_q <= cmd_addr;
            wdata_q <= cmd_wdata;
            cnt_q <= cfg_mux ? ALE_CYC : SETUP_CYC;
            state_q <= cfg_mux ? HCBP_ALE : HCBP_SETUP;
          end
        end
        HCBP_ALE: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == 1) begin
            cnt_q <= ALE_CYC;
            state_q <= HCBP_LATCH;
          end
        end
        HCBP_LATCH: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == 1) begin
            cnt_q <= SETUP_CYC;
            state_q <= HCBP_SETUP;
          end
        end
        HCBP_SETUP: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == 1) begin
            cnt_q <= strobe_len;
            state_q <= HCBP_STROBE;
          end
        end
        HCBP_STROBE: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == 1) begin
            cnt_q <= HOLD_CYC;
            state_q <= HCBP_HOLD;
          end
        end
        HCBP_HOLD: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == 1) begin
            state_q <= HCBP_IDLE;
          end
        end
        default: begin
          state_q <= HCBP_IDLE;
        end
      endcase
    end
  end

  // pin drive registered from the current state of the sequencer, one cycle behind it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= '0;
      mux_n_q <= 1'b1;
      cs_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      hdata_q <= '0;
      hdata_oe_n_q <= 1'b1;
    end else begin
      mux_n_q <= !cfg_mux; // see [R2]
      cs_n_q <= !(state_q == HCBP_SETUP || state_q == HCBP_STROBE || state_q == HCBP_HOLD); // see [R11]
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      hdata_oe_n_q <= 1'b1;
      if (cfg_mux) begin
        // ALE on the top index pin, middle pin driven high
        idx_q <= {state_q == HCBP_ALE, 1'b1, 1'b0}; // see [R2]
      end else begin
        idx_q <= addr_q; // see [R1]
      end
      if (state_q == HCBP_ALE || state_q == HCBP_LATCH) begin
        hdata_q <= {{(DATA_W-LOW_W){1'b0}}, addr_q}; // see [R3] [R4]
        hdata_oe_n_q <= 1'b0;
      end else if (state_q != HCBP_IDLE && write_q) begin
        hdata_q <= wdata_q;
        hdata_oe_n_q <= 1'b0;
      end
      if (state_q == HCBP_SETUP || state_q == HCBP_STROBE || state_q == HCBP_HOLD) begin
        if (cfg_cpu == HCBP_CPU_68XX) begin
          wr_n_q <= !write_q; // see [R7]
          rd_n_q <= !(state_q == HCBP_STROBE); // see [R8]
        end else begin
          wr_n_q <= !(write_q && state_q == HCBP_STROBE); // see [R5]
          rd_n_q <= !(!write_q && state_q == HCBP_STROBE); // see [R6]
        end
      end
    end
  end

  // reset pin, timing select, irq and handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_n_q <= 1'b0;
      speed_oe_n_q <= 1'b1;
      irq_pending_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
    end else begin
      rst_pin_n_q <= !reset_req; // see [R9]
      speed_oe_n_q <= !fast_ok; // see [R12] [R13]
      irq_pending_q <= !in_s[DATA_W]; // see [R10]
      cmd_ready_q <= state_q == HCBP_IDLE && !(cmd_valid && cmd_ready_q) && !reset_req;
      rsp_valid_q <= state_q == HCBP_HOLD && cnt_q == 1;
      if (state_q == HCBP_STROBE && cnt_q == 1 && !write_q) begin
        rsp_rdata_q <= in_s[DATA_W-1:0];
      end
    end
  end

  assign bus.bus_mode_select_n = mux_n_q;
  assign bus.host_reg_index = idx_q;
  assign bus.chip_select_n = cs_n_q;
  assign bus.write_strobe_n = wr_n_q;
  assign bus.read_strobe_n = rd_n_q;
  assign bus.hw_reset_n = rst_pin_n_q;
  assign bus.speed_o = 1'b0;
  assign bus.speed_oe_n = speed_oe_n_q;
  assign bus.host_data_o = hdata_q;
  assign bus.host_data_oe_n = hdata_oe_n_q;

endmodule

//--- hcbp_monitor.sv
// pin checks between the host end and the device end of the port
// assumes it sits beside the pin bundle; one clock domain
`timescale 1ns/1ns
module hcbp_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host driven pins
  input wire logic bus_mode_select_n,
  input wire logic [hcbp_pkg::ADDR_W-1:0] host_reg_index,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic hw_reset_n,
  // device driven pins
  input wire logic [hcbp_pkg::DATA_W-1:0] dev_data_o,
  input wire logic dev_data_oe_n,
  input wire logic irq_out_n
);
  import hcbp_pkg::*;
  // all checks share the clock and stay quiet in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // bus drive only begins inside a selected read
  chk_drive_in_read: assert property ($fell(dev_data_oe_n) |->
    !chip_select_n && !read_strobe_n && write_strobe_n)
    else $error("data drive began outside a read");
  // a selected read gets the bus driven in time
  chk_read_drives: assert property ($fell(read_strobe_n) && write_strobe_n && !chip_select_n && hw_reset_n
    |-> ##[2:6] !dev_data_oe_n)
    else $error("read strobe not answered by data drive");
  // the bus is let go soon after the strobe ends
  chk_drive_ends: assert property ($rose(read_strobe_n) |-> ##[1:5] dev_data_oe_n)
    else $error("data drive held after read strobe");
  // nothing driven while the chip is not selected
  chk_idle_quiet: assert property (chip_select_n [*6] |-> dev_data_oe_n)
    else $error("data driven while not selected");
  // a write or write direction never turns the bus round
  chk_write_quiet: assert property (!write_strobe_n |-> dev_data_oe_n)
    else $error("data driven during a write");
  // address phase of the shared lines belongs to the host
  chk_ale_quiet: assert property (!bus_mode_select_n && host_reg_index[ALE_BIT] |-> dev_data_oe_n)
    else $error("data driven during address latch");
  // hardware reset silences the bus
  chk_reset_quiet: assert property (!hw_reset_n [*4] |-> dev_data_oe_n)
    else $error("data driven in hardware reset");
  // hardware reset withdraws the interrupt
  chk_reset_irq: assert property (!hw_reset_n [*5] |-> irq_out_n)
    else $error("interrupt asserted in hardware reset");
  // read data holds steady once driven
  chk_data_steady: assert property (!dev_data_oe_n && !$past(dev_data_oe_n) && !$past(dev_data_oe_n, 2)
    |-> $stable(dev_data_o))
    else $error("read data changed while driven");
endmodule

//--- hcbp_pkg.sv
// shared constants and types for the host cpu bus port
// assumes a single 100 MHz clock shared by both ends of the port
package hcbp_pkg;

  // bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int LOW_W = 3;
  localparam int ALE_BIT = 2;
  localparam int OPEN_BIT = 1;
  localparam logic [DATA_W-1:0] BUS_PULLED = 8'hff;

  // synchroniser depth and reset images of the device and host pin bundles
  localparam int SYNC_LEN = 2;
  localparam int DEV_PIN_W = 6 + ADDR_W + DATA_W;
  localparam logic [DEV_PIN_W-1:0] DEV_PIN_RST = 17'h1_ffff;
  localparam int HOST_PIN_W = 1 + DATA_W;
  localparam logic [HOST_PIN_W-1:0] HOST_PIN_RST = 9'h1ff;

  // host access timing, in ns, turned into whole clock cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int ALE_NS = 30;
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 120;
  localparam int STROBE_FAST_NS = 80;
  localparam int HOLD_NS = 30;
  localparam int CNT_W = 4;

  // least time rounds up, never below one cycle
  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction

  localparam logic [CNT_W-1:0] ALE_CYC = ns_to_cyc(ALE_NS);
  localparam logic [CNT_W-1:0] SETUP_CYC = ns_to_cyc(SETUP_NS);
  localparam logic [CNT_W-1:0] STROBE_CYC = ns_to_cyc(STROBE_NS);
  localparam logic [CNT_W-1:0] STROBE_FAST_CYC = ns_to_cyc(STROBE_FAST_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC = ns_to_cyc(HOLD_NS);

  // strobe style of the attached cpu
  typedef enum logic {
    HCBP_CPU_80XX = 1'b0,
    HCBP_CPU_68XX = 1'b1
  } hcbp_cpu_e;

  // host sequencer states
  typedef enum logic [2:0] {
    HCBP_IDLE = 3'b000,
    HCBP_ALE = 3'b001,
    HCBP_LATCH = 3'b010,
    HCBP_SETUP = 3'b011,
    HCBP_STROBE = 3'b100,
    HCBP_HOLD = 3'b101
  } hcbp_hstate_e;

endpackage

//--- hcbp_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
// assumes each bit is a level; bits are not coherent with each other
`timescale 1ns/1ns
module hcbp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- host_cpu_bus_port_test.sv
// testbench joining host end and device end over the pin bundle
// assumes the bench plays the register file and the host command user
`timescale 1ns/1ns
module host_cpu_bus_port_test;
  import hcbp_pkg::*;
  // stimulus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_mux = 1'b0, cfg_fast = 1'b0, reset_req = 1'b0, irq_req = 1'b0;
  hcbp_cpu_e style = HCBP_CPU_80XX;
  logic cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0;
  // design outputs
  logic cmd_ready_q, rsp_valid_q, irq_pending_q, reg_wr_pulse_q, reg_rd_pulse_q;
  logic device_reset_q, fast_timing_q, timing_conflict_q;
  logic [DATA_W-1:0] rsp_rdata_q, reg_wr_data_q, reg_rd_data;
  logic [ADDR_W-1:0] reg_addr_q;
  // register file and expected contents
  logic [DATA_W-1:0] regs [8];
  logic [DATA_W-1:0] exp_regs [8];
  int exp_lat;
  int failures = 0;
  int checks = 0;
  int rd_pulses = 0;

  // clock
  always #5 clk = ~clk;

  hcbp_bus_if u_hcbp_bus_if ();
  hcbp_dev_end u_hcbp_dev_end (.clk(clk), .rst_n(rst_n), .bus(u_hcbp_bus_if), .cpu_style(style),
    .reg_addr_q(reg_addr_q), .reg_wr_pulse_q(reg_wr_pulse_q), .reg_wr_data_q(reg_wr_data_q),
    .reg_rd_pulse_q(reg_rd_pulse_q), .reg_rd_data(reg_rd_data), .irq_req(irq_req),
    .device_reset_q(device_reset_q), .fast_timing_q(fast_timing_q), .timing_conflict_q(timing_conflict_q));
  hcbp_host_end u_hcbp_host_end (.clk(clk), .rst_n(rst_n), .bus(u_hcbp_bus_if), .cfg_mux(cfg_mux),
    .cfg_cpu(style), .cfg_fast(cfg_fast), .reset_req(reset_req), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready_q(cmd_ready_q),
    .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .irq_pending_q(irq_pending_q));
  hcbp_monitor u_hcbp_monitor (.clk(clk), .rst_n(rst_n),
    .bus_mode_select_n(u_hcbp_bus_if.bus_mode_select_n), .host_reg_index(u_hcbp_bus_if.host_reg_index),
    .chip_select_n(u_hcbp_bus_if.chip_select_n), .write_strobe_n(u_hcbp_bus_if.write_strobe_n),
    .read_strobe_n(u_hcbp_bus_if.read_strobe_n), .hw_reset_n(u_hcbp_bus_if.hw_reset_n),
    .dev_data_o(u_hcbp_bus_if.dev_data_o), .dev_data_oe_n(u_hcbp_bus_if.dev_data_oe_n),
    .irq_out_n(u_hcbp_bus_if.irq_out_n));

  // register file behind the device end
  initial foreach (regs[i]) regs[i] = '0;
  always @(posedge clk) begin
    if (reg_wr_pulse_q === 1'b1) begin
      regs[reg_addr_q] <= reg_wr_data_q;
    end
  end
  assign reg_rd_data = regs[reg_addr_q];
  // count read pulses seen by the register file
  always @(posedge clk) begin
    if (reg_rd_pulse_q === 1'b1) begin
      rd_pulses++;
    end
  end

  // comparisons
  task automatic cmp_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_count(input int got, input int exp);
    checks++;
    if (got != exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one host command, cycles counted from take to answer
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output int lat);
    int n;
    n = 0;
    while (cmd_ready_q !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    lat = 0;
    while (rsp_valid_q !== 1'b1 && lat < 60) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int lat;
    access(1'b1, a, d, lat);
    exp_regs[a] = d;
    cmp_count(lat, exp_lat);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    int lat;
    int n0;
    n0 = rd_pulses;
    access(1'b0, a, 8'h00, lat);
    cmp_count(lat, exp_lat);
    cmp_byte(rsp_rdata_q, exp_regs[a]);
    cmp_count(rd_pulses - n0, 1);
  endtask

  // verdict
  task automatic wrap_up;
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #100_000;
    failures++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    cmp_bit(irq_pending_q, 1'b0);
    // every strobe style, bus mode and speed, all eight registers
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      style <= hcbp_cpu_e'(c[0]);
      cfg_mux <= c[1];
      cfg_fast <= c[2];
      repeat (6) @(posedge clk);
      #1;
      exp_lat = c[1] ? 24 : (c[2] ? 14 : 18);
      for (int a = 0; a < 8; a++) begin
        wr(a[2:0], 8'(a * 8'h25 + c * 8'h51));
      end
      for (int a = 7; a >= 0; a--) begin
        rd(a[2:0]);
      end
      cmp_bit(fast_timing_q, c[2] & !c[1]);
      // the host end never pulls the select low in muxed mode, so no conflict shows
      cmp_bit(timing_conflict_q, 1'b0);
    end
    // interrupt raised and withdrawn
    @(posedge clk);
    irq_req <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    cmp_bit(irq_pending_q, 1'b1);
    @(posedge clk);
    irq_req <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    cmp_bit(irq_pending_q, 1'b0);
    // hardware reset with a pending interrupt, then recovery
    @(posedge clk);
    irq_req <= 1'b1;
    reset_req <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    cmp_bit(device_reset_q, 1'b1);
    cmp_bit(irq_pending_q, 1'b0);
    @(posedge clk);
    reset_req <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    cmp_bit(device_reset_q, 1'b0);
    cmp_bit(irq_pending_q, 1'b1);
    rd(3'h5);
    wrap_up();
  end
endmodule
